// >>> rtl/imdr_diag_record.sv
// Purpose: Diagnostic record of an eight-channel digital input module.
// Assumes: Requests and fault inputs are synchronous to clk.
// Notes:   One request per cycle; the answer byte follows one cycle later.

module imdr_diag_record
    import imdr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_path,
    input  wire logic [15:0] object_index,
    input  wire logic [7:0]  object_subindex,
    input  wire logic [7:0]  record_set_number,
    input  wire logic [4:0]  req_offset,
    input  wire logic [7:0]  open_wire_detect_enable,
    input  wire logic        param_load,
    input  wire logic [7:0]  param_error,
    input  wire logic [7:0]  wire_break,
    input  wire logic        module_failure,
    input  wire logic        external_error,
    input  wire logic        aux_supply_missing,
    input  wire logic        diag_buffer_overflow,
    input  wire logic        internal_comm_error,
    output logic             rsp_valid,
    output logic             rsp_error,
    output logic [7:0]       rsp_data,
    output logic [7:0]       rsp_length,
    output logic [31:0]      us_ticker
);

    // Prescaler and ticker state
    logic [5:0]  pre_q, pre_d;          // Cycle count within a microsecond
    logic [31:0] tick_q, tick_d;        // Free-running microsecond count
    // Diagnostic state
    logic [7:0]  wben_q, wben_d;        // Wire break enables in force
    logic [7:0]  detail_q [8];          // Per-input detail bytes
    logic [7:0]  detail_d [8];
    logic [7:0]  map_q, map_d;          // Channel error map
    logic [7:0]  sum_q, sum_d;          // Fault summary
    logic [7:0]  int_q, int_d;          // Internal fault flags
    logic [31:0] stamp_q, stamp_d;      // Ticker at last diagnostic event
    // Answer state
    logic        rv_q, rv_d;
    logic        re_q, re_d;
    logic [7:0]  rd_q, rd_d;
    logic [7:0]  rl_q, rl_d;
    // Helpers
    logic        event_now;             // A fault rose in the picture this cycle
    logic [4:0]  sel;                   // Record byte selected by request
    logic        hit;                   // Request names a served object
    logic [4:0]  len;                   // Bytes served by the request
    logic [7:0]  rec_byte;              // Byte at sel

    // Ticker: enable pulse every TICK_CYCLES clocks
    always_comb begin
        pre_d  = pre_q;
        tick_d = tick_q;
        if (pre_q == TICK_LAST) begin
            pre_d  = 6'h00;
            tick_d = tick_q + 32'h0000_0001; // Natural wrap
        end else begin
            pre_d = pre_q + 6'h01;
        end
    end

    // Ticker registers, cleared at reset
    always_ff @(posedge clk) begin
        if (srst) begin
            pre_q  <= 6'h00;
            tick_q <= ZERO_WORD;
        end else begin
            pre_q  <= pre_d;
            tick_q <= tick_d;
        end
    end

    // Fault picture from the inputs
    always_comb begin
        wben_d = wben_q;
        // Enables only change when the head unit loads them
        if (param_load) begin
            wben_d = open_wire_detect_enable;
        end
        for (int i = 0; i < 8; i++) begin
            detail_d[i] = ZERO_BYTE;          // Reserved bits zero
            detail_d[i][DET_PARAM] = param_error[i];
            detail_d[i][DET_WIRE]  = wire_break[i] & wben_q[i];
            map_d[i] = (detail_d[i] != ZERO_BYTE);
        end
        sum_d = ZERO_BYTE;
        sum_d[SUM_MODFAIL]  = module_failure;
        sum_d[SUM_INTERNAL] = diag_buffer_overflow | internal_comm_error;
        sum_d[SUM_EXTERNAL] = external_error | aux_supply_missing;
        sum_d[SUM_CHANNEL]  = |map_d;
        sum_d[SUM_AUXSUP]   = aux_supply_missing;
        sum_d[SUM_PARAM]    = |param_error;
        int_d = ZERO_BYTE;
        int_d[INT_OVERFLOW] = diag_buffer_overflow;
        int_d[INT_COMM]     = internal_comm_error;
        // A new fault rising is the diagnostic event
        event_now = (sum_d & ~sum_q) != ZERO_BYTE ||
                    (map_d & ~map_q) != ZERO_BYTE;
        stamp_d = event_now ? tick_q : stamp_q;
    end

    // Fault registers
    always_ff @(posedge clk) begin
        if (srst) begin
            wben_q  <= ZERO_BYTE;
            map_q   <= ZERO_BYTE;
            sum_q   <= ZERO_BYTE;
            int_q   <= ZERO_BYTE;
            stamp_q <= ZERO_WORD;
            for (int i = 0; i < 8; i++) begin
                detail_q[i] <= ZERO_BYTE;
            end
        end else begin
            wben_q  <= wben_d;
            map_q   <= map_d;
            sum_q   <= sum_d;
            int_q   <= int_d;
            stamp_q <= stamp_d;
            for (int i = 0; i < 8; i++) begin
                detail_q[i] <= detail_d[i];
            end
        end
    end

    // Decode request into a byte selection and a served length
    always_comb begin
        sel = req_offset;
        hit = 1'b0;
        len = LEN_FULL;
        case (req_path)
            PATH_DS: begin
                if (record_set_number == DS_FULL) begin
                    hit = 1'b1;
                end else if (record_set_number == DS_HEAD) begin
                    hit = 1'b1;
                    len = LEN_HEAD;
                end
            end
            PATH_CAN: begin
                if (object_index == IX_FULL) begin
                    hit = 1'b1;
                end else if (object_index == IX_HEAD) begin
                    hit = 1'b1;
                    len = LEN_HEAD;
                end
            end
            PATH_ECAT: begin
                // One subindex per byte; stamp word spans four bytes
                if (object_index == IX_ECAT &&
                    object_subindex >= SX_FIRST &&
                    object_subindex <= SX_DETAIL7) begin
                    hit = 1'b1;
                    sel = 5'(object_subindex - SX_FIRST);
                    len = 5'h01;
                end else if (object_index == IX_ECAT &&
                             object_subindex == SX_STAMP) begin
                    hit = 1'b1;
                    sel = BYTE_STAMP + 5'(req_offset[1:0]);
                    len = 5'h04;
                end
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (req_path != PATH_ECAT && req_offset >= len) begin
            hit = 1'b0;                  // Past the served length
        end
    end

    // Record byte multiplexer
    always_comb begin
        rec_byte = ZERO_BYTE;
        case (sel)
            B_SUMMARY:  rec_byte = sum_q;
            B_CLASS:    rec_byte = CLASS_VAL;
            B_RSVD:     rec_byte = ZERO_BYTE;
            B_INTERNAL: rec_byte = int_q;
            B_KIND:     rec_byte = KIND_VAL;
            B_BITS:     rec_byte = BITS_VAL;
            B_COUNT:    rec_byte = COUNT_VAL;
            B_MAP:      rec_byte = map_q;
            default: begin
                if (sel >= B_DETAIL0 && sel < BYTE_STAMP) begin
                    rec_byte = detail_q[3'(sel - B_DETAIL0)];
                end else if (sel >= BYTE_STAMP && sel < LEN_FULL) begin
                    // Stamp bytes go out least significant first
                    rec_byte = stamp_q[8*(2'(sel - BYTE_STAMP)) +: 8];
                end
            end
        endcase
    end

    // Answer next values
    always_comb begin
        rv_d = req_valid;
        re_d = req_valid & ~hit;
        rd_d = (req_valid & hit) ? rec_byte : ZERO_BYTE;
        rl_d = (req_valid & hit) ? {3'h0, len} : ZERO_BYTE;
    end

    // Answer registers
    always_ff @(posedge clk) begin
        if (srst) begin
            rv_q <= 1'b0;
            re_q <= 1'b0;
            rd_q <= ZERO_BYTE;
            rl_q <= ZERO_BYTE;
        end else begin
            rv_q <= rv_d;
            re_q <= re_d;
            rd_q <= rd_d;
            rl_q <= rl_d;
        end
    end

    assign rsp_valid  = rv_q;
    assign rsp_error  = re_q;
    assign rsp_data   = rd_q;
    assign rsp_length = rl_q;
    assign us_ticker  = tick_q;

    // Checks
    chk_ticker_step: assert property (@(posedge clk) disable iff (srst)
        pre_q == TICK_LAST |=> tick_q == $past(tick_q) + 32'h1)
        else $error("ticker did not step");
    chk_ticker_hold: assert property (@(posedge clk) disable iff (srst)
        pre_q != TICK_LAST |=> $stable(tick_q))
        else $error("ticker moved early");
    chk_head_len: assert property (@(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_DS && record_set_number == DS_HEAD
        && req_offset >= LEN_HEAD |=> rsp_error)
        else $error("head record served too far");
    chk_can_len: assert property (@(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_CAN && object_index == IX_FULL
        && req_offset < LEN_FULL |=> !rsp_error && rsp_length == 8'h14)
        else $error("full can record refused");
    chk_ecat_class: assert property (@(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_ECAT && object_index == IX_ECAT
        && object_subindex == 8'h03 |=> rsp_data == CLASS_VAL)
        else $error("class byte wrong");
    chk_wire_gate: assert property (@(posedge clk) disable iff (srst)
        wire_break[0] && !wben_q[0] |=> !detail_q[0][DET_WIRE])
        else $error("wire break reported while disabled");
    chk_chan_flag: assert property (@(posedge clk) disable iff (srst)
        map_q != ZERO_BYTE |-> sum_q[SUM_CHANNEL])
        else $error("channel flag missing");
    chk_stamp_take: assert property (@(posedge clk) disable iff (srst)
        $rose(module_failure) && !sum_q[SUM_MODFAIL]
        |=> stamp_q == $past(tick_q))
        else $error("stamp not captured");
    chk_rsvd_zero: assert property (@(posedge clk) disable iff (srst)
        (sum_q[6:5] == 2'h0) && (int_q[2:0] == 3'h0))
        else $error("reserved bits set");

    // Every taken request gets exactly one answer strobe
    chk_rsp_pulse: assert property (
        @(posedge clk) disable iff (srst)
        req_valid |=> rsp_valid)
        else $error("answer strobe missing");
    // No answer without a request, so the head unit never miscounts
    chk_rsp_quiet: assert property (
        @(posedge clk) disable iff (srst)
        !req_valid |=> !rsp_valid)
        else $error("answer without request");
    // A refused request carries no stale byte or length
    chk_err_clean: assert property (
        @(posedge clk) disable iff (srst)
        rsp_error |-> rsp_data == ZERO_BYTE && rsp_length == ZERO_BYTE)
        else $error("refused answer not clean");
    // Full record on the record-set path serves all bytes
    chk_ds_full: assert property (
        @(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_DS && record_set_number == DS_FULL
        && req_offset < LEN_FULL |=> !rsp_error && rsp_length == 8'h14)
        else $error("full record refused");
    // Short CAN object stops after its four bytes
    chk_can_head: assert property (
        @(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_CAN && object_index == IX_HEAD
        && req_offset >= LEN_HEAD |=> rsp_error)
        else $error("short can object served too far");
    // Single-byte subindexes report a length of one
    chk_ecat_len: assert property (
        @(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_ECAT && object_index == IX_ECAT
        && object_subindex >= SX_FIRST && object_subindex <= SX_DETAIL7
        |=> !rsp_error && rsp_length == 8'h01)
        else $error("subindex length wrong");
    // Channel kind byte sits at subindex 06h
    chk_ecat_kind: assert property (
        @(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_ECAT && object_index == IX_ECAT
        && object_subindex == 8'h06 |=> rsp_data == KIND_VAL)
        else $error("kind byte wrong");
    // Constant bit count byte
    chk_bits_byte: assert property (
        @(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_DS && record_set_number == DS_FULL
        && req_offset == B_BITS |=> rsp_data == BITS_VAL)
        else $error("bits byte wrong");
    // Constant channel count byte
    chk_count_byte: assert property (
        @(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_DS && record_set_number == DS_FULL
        && req_offset == B_COUNT |=> rsp_data == COUNT_VAL)
        else $error("count byte wrong");
    // The reserved byte never leaks anything
    chk_rsvd_byte: assert property (
        @(posedge clk) disable iff (srst)
        req_valid && req_path == PATH_DS && record_set_number == DS_FULL
        && req_offset == B_RSVD |=> rsp_data == ZERO_BYTE)
        else $error("reserved byte not zero");
    // Map bit follows its detail byte in the same cycle
    chk_map_bit: assert property (
        @(posedge clk) disable iff (srst)
        map_q[7] == (detail_q[7] != ZERO_BYTE))
        else $error("map bit out of step");
    // Detail byte 3 keeps its reserved bits clear
    chk_detail_rsvd: assert property (
        @(posedge clk) disable iff (srst)
        detail_q[3][3:1] == 3'h0 && detail_q[3][7:5] == 3'h0)
        else $error("detail reserved bits set");
    // Internal flags follow their fault levels one cycle later
    chk_int_flags: assert property (
        @(posedge clk) disable iff (srst)
        1'b1 |=> int_q[INT_OVERFLOW] == $past(diag_buffer_overflow)
        && int_q[INT_COMM] == $past(internal_comm_error))
        else $error("internal flags wrong");
    // Parameter flag summarises every input
    chk_sum_param: assert property (
        @(posedge clk) disable iff (srst)
        1'b1 |=> sum_q[SUM_PARAM] == |$past(param_error))
        else $error("parameter flag wrong");
    // Enables only move on a load, never on their own
    chk_wben_hold: assert property (
        @(posedge clk) disable iff (srst)
        !param_load |=> $stable(wben_q))
        else $error("enables moved without load");
    // Reset restarts the ticker from zero
    chk_tick_clear: assert property (
        @(posedge clk)
        srst |=> tick_q == ZERO_WORD && pre_q == 6'h00)
        else $error("ticker not cleared");
    // Channel flag only stands with a mapped channel behind it
    chk_chan_src: assert property (
        @(posedge clk) disable iff (srst)
        sum_q[SUM_CHANNEL] |-> map_q != ZERO_BYTE)
        else $error("channel flag without channel");
endmodule

// >>> include/imdr_pkg.sv
// Purpose: Constants for the input module diagnostic record.
// Assumes: 40 MHz module clock, synchronous active-high reset.
// Notes:   Byte layout follows the EtherCAT subindex order.
package imdr_pkg;
    // Clock and ticker timing
    localparam int unsigned CLK_HZ        = 40000000;
    localparam int unsigned TICK_US       = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;
    localparam logic [5:0]  TICK_LAST     = 6'(TICK_CYCLES - 1);

    // Access paths
    localparam logic [1:0]  PATH_DS       = 2'h0;
    localparam logic [1:0]  PATH_CAN      = 2'h1;
    localparam logic [1:0]  PATH_ECAT     = 2'h2;

    // Record and object numbers
    localparam logic [7:0]  DS_HEAD       = 8'h00;
    localparam logic [7:0]  DS_FULL       = 8'h01;
    localparam logic [15:0] IX_HEAD       = 16'h2f00;
    localparam logic [15:0] IX_FULL       = 16'h2f01;
    localparam logic [15:0] IX_ECAT       = 16'h5005;
    localparam logic [7:0]  SX_FIRST      = 8'h02;
    localparam logic [7:0]  SX_DETAIL0    = 8'h0a;
    localparam logic [7:0]  SX_DETAIL7    = 8'h11;
    localparam logic [7:0]  SX_STAMP      = 8'h13;

    // Record lengths and stamp byte offset in bytes
    localparam logic [4:0]  LEN_FULL      = 5'h14;
    localparam logic [4:0]  LEN_HEAD      = 5'h04;
    localparam logic [4:0]  BYTE_STAMP    = 5'h10;

    // Byte indices in the record
    localparam logic [4:0]  B_SUMMARY     = 5'h00;
    localparam logic [4:0]  B_CLASS       = 5'h01;
    localparam logic [4:0]  B_RSVD        = 5'h02;
    localparam logic [4:0]  B_INTERNAL    = 5'h03;
    localparam logic [4:0]  B_KIND        = 5'h04;
    localparam logic [4:0]  B_BITS        = 5'h05;
    localparam logic [4:0]  B_COUNT       = 5'h06;
    localparam logic [4:0]  B_MAP         = 5'h07;
    localparam logic [4:0]  B_DETAIL0     = 5'h08;

    // Field positions
    localparam int unsigned SUM_MODFAIL   = 0;
    localparam int unsigned SUM_INTERNAL  = 1;
    localparam int unsigned SUM_EXTERNAL  = 2;
    localparam int unsigned SUM_CHANNEL   = 3;
    localparam int unsigned SUM_AUXSUP    = 4;
    localparam int unsigned SUM_PARAM     = 7;
    localparam int unsigned INT_OVERFLOW  = 3;
    localparam int unsigned INT_COMM      = 4;
    localparam int unsigned DET_PARAM     = 0;
    localparam int unsigned DET_WIRE      = 4;

    // Constant and reset values
    localparam logic [7:0]  CLASS_VAL     = 8'h1f;
    localparam logic [7:0]  KIND_VAL      = 8'h70;
    localparam logic [7:0]  BITS_VAL      = 8'h08;
    localparam logic [7:0]  COUNT_VAL     = 8'h08;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage

// >>> verif/imdr_head_unit.sv
// Purpose: Head unit model that reads the record and loads enables.
// Assumes: Drives 2 ns after the rising edge of clk.
// Notes:   Reads are one-cycle strobes and may run back to back.
module imdr_head_unit (
    input  wire logic   clk,
    output logic        req_valid,
    output logic [1:0]  req_path,
    output logic [15:0] object_index,
    output logic [7:0]  object_subindex,
    output logic [7:0]  record_set_number,
    output logic [4:0]  req_offset,
    output logic [7:0]  open_wire_detect_enable,
    output logic        param_load
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet bus from time zero
    initial begin
        {req_valid, req_path, object_index} = '0;
        {object_subindex, record_set_number, req_offset} = '0;
        {open_wire_detect_enable, param_load} = '0;
    end

    // One read request, held until the next sampling edge
    task automatic rd(logic [1:0] p, logic [15:0] ix, logic [7:0] sx,
                      logic [7:0] ds, logic [4:0] off);
        @(posedge clk);
        #2;
        {req_valid, req_path, object_index} = {1'b1, p, ix};
        {object_subindex, record_set_number, req_offset} = {sx, ds, off};
    endtask

    // Drop the strobe; index and offset flip so stale values are never reused
    task automatic idle();
        @(posedge clk);
        #2;
        req_valid = 1'b0;
        {object_index, req_offset} = ~{object_index, req_offset};
    endtask

    // Enable load; the bench only calls it in its stopped phase
    task automatic load(logic [7:0] en);
        @(posedge clk);
        #2;
        open_wire_detect_enable = en;
        param_load = 1'b1;
        @(posedge clk);
        #2;
        param_load = 1'b0;
    endtask
endmodule

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the diagnostic record.
// Assumes: Inputs change 2 ns after the rising edge of clk.
// Notes:   Ticker wrap takes 2^32 us, so it is not reached here.
module testbench
    import imdr_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {logic e; logic [7:0] l, d;} imdr_exp_t;
    logic        clk, srst, req_valid, param_load, rsp_valid, rsp_error;
    logic        mf, ext, aux, ovf, com;  // Module fault levels
    logic [1:0]  req_path;
    logic [15:0] object_index;
    logic [7:0]  object_subindex, record_set_number, open_wire_detect_enable;
    logic [7:0]  perr, wbrk, en_m, rsp_data, rsp_length;
    logic [4:0]  req_offset;
    logic [31:0] us_ticker, stamp;
    logic [7:0]  rec [20];               // Expected record bytes
    imdr_exp_t   expq [$];               // Pending answer notes
    int          cyc, ticks, num_errors, n_tests;

    imdr_diag_record DUT (.clk, .srst, .req_valid, .req_path, .object_index,
        .object_subindex, .record_set_number, .req_offset, .param_load,
        .open_wire_detect_enable, .param_error(perr), .wire_break(wbrk),
        .module_failure(mf), .external_error(ext), .aux_supply_missing(aux),
        .diag_buffer_overflow(ovf), .internal_comm_error(com), .rsp_valid,
        .rsp_error, .rsp_data, .rsp_length, .us_ticker);
    imdr_head_unit hu (.clk, .req_valid, .req_path, .object_index,
        .object_subindex, .record_set_number, .req_offset,
        .open_wire_detect_enable, .param_load);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cycles since release; a hang ends the run as a mismatch
    always @(posedge clk) begin
        cyc <= srst ? 0 : cyc + 1;
        ticks <= ticks + 1;
        if (ticks == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic check(logic [31:0] seen, logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // Rebuild expected bytes; a rising flag takes a new stamp
    task automatic build();
        logic [15:0] old;
        old = {rec[0], rec[7]};
        for (int n = 0; n < 8; n++) begin
            rec[8+n] = {3'h0, wbrk[n] & en_m[n], 3'h0, perr[n]};
            rec[7][n] = |rec[8+n];
        end
        rec[0] = {|perr, 2'h0, aux, |rec[7], ext | aux, ovf | com, mf};
        {rec[1], rec[2], rec[3]} = {16'h1f00, 3'h0, com, ovf, 3'h0};
        {rec[4], rec[5], rec[6]} = 24'h700808;
        if (|({rec[0], rec[7]} & ~old))
            stamp = 32'(cyc / 40);
        {rec[19], rec[18], rec[17], rec[16]} = stamp;
    endtask

    function automatic imdr_exp_t expect_of(logic [1:0] p, logic [15:0] ix,
        logic [7:0] sx, logic [7:0] ds, logic [4:0] off);
        logic [7:0] len;
        len = 8'h00;
        if (p == 2'h0 && ds == 8'h01 || p == 2'h1 && ix == 16'h2f01)
            len = 8'h14;
        if (p == 2'h0 && ds == 8'h00 || p == 2'h1 && ix == 16'h2f00)
            len = 8'h04;
        if (8'(off) < len)
            return {1'b0, len, rec[off]};
        if (p == 2'h2 && ix == 16'h5005 && sx inside {[8'h02:8'h11]})
            return {1'b0, 8'h01, rec[sx - 8'h02]};
        if (p == 2'h2 && ix == 16'h5005 && sx == 8'h13)
            return {1'b0, 8'h04, rec[5'h10 + off[1:0]]};
        return {1'b1, 8'h00, 8'h00};
    endfunction

    task automatic rd(logic [1:0] p, logic [15:0] ix, logic [7:0] sx,
                      logic [7:0] ds, logic [4:0] off);
        hu.rd(p, ix, sx, ds, off);
        expq.push_back(expect_of(p, ix, sx, ds, off));
    endtask

    // Faults change mid-tick so the stamp cannot straddle a step
    task automatic faults();
        logic [7:0] en;
        while (cyc % 40 != 15) begin
            @(posedge clk);
            #2;
        end
        en = 8'($urandom);
        hu.load(en);
        en_m = en;
        // One rebuild only: the design sees the new enables and faults
        // in the same edge, so an in-between picture must not stamp
        {mf, ext, aux, ovf, com} = 5'($urandom);
        perr = 8'($urandom & $urandom);
        wbrk = 8'($urandom);
        build();
    endtask

    // Each answer is compared with the oldest pending note
    always @(negedge clk) begin
        if (rsp_valid !== 1'b0)
            check(32'({rsp_error, rsp_length, rsp_data}),
                  expq.size() ? 32'(expq.pop_front()) : 32'hffff_ffff);
    end

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        logic [1:0] p;
        srst = 1'b1;
        {mf, ext, aux, ovf, com, perr, wbrk, en_m, stamp} = '0;
        void'($urandom(81));
        build();
        repeat (2) @(posedge clk);
        #2;
        srst = 1'b0;
        // Reset image through the whole record
        for (int o = 0; o < 20; o++)
            rd(PATH_DS, '0, '0, DS_FULL, 5'(o));
        hu.idle();
        // Random faults, read back over random paths without gaps
        repeat (6) begin
            faults();
            for (int o = 0; o < 20; o++) begin
                p = 2'($urandom_range(2));
                rd(p, p == PATH_CAN ? IX_FULL : IX_ECAT,
                   o < 16 ? 8'(o + 2) : SX_STAMP, DS_FULL, 5'(o));
            end
            hu.idle();
        end
        // Short records, edges of each address space, refused places
        rd(PATH_DS, '0, '0, DS_HEAD, 5'h03);
        rd(PATH_DS, '0, '0, DS_HEAD, 5'h04);
        rd(PATH_CAN, IX_HEAD, '0, '0, 5'h03);
        rd(PATH_CAN, IX_HEAD, '0, '0, 5'h04);
        rd(PATH_CAN, IX_FULL, '0, '0, 5'h14);
        rd(PATH_ECAT, IX_ECAT, 8'h12, '0, '0);
        rd(PATH_ECAT, IX_ECAT, 8'h01, '0, '0);
        rd(PATH_ECAT, IX_FULL, SX_FIRST, '0, '0);
        rd(2'h3, IX_ECAT, SX_FIRST, DS_FULL, '0);
        rd(PATH_DS, '0, '0, 8'h02, '0);
        repeat (50) hu.idle();
        check(us_ticker, 32'(cyc / 40));
        check(32'(expq.size()), 32'h0);
        print_verdict();
    end
endmodule
